// File: psc_pkg.sv
/*
  package for the serial command dma controller: register offsets,
  field positions, reset values, timing counts, states and carriers.
  assumes a 40 mhz system clock and apb-style register access.
*/
`default_nettype none
package psc_pkg;
  // clock and link rates
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned RATE_MAX_BPS = 2_000_000;
  localparam int unsigned RATE_MIN_BPS = 250_000;
  localparam int unsigned HP_MIN_CYC = CLK_HZ / (2 * RATE_MAX_BPS);
  // wait inserted by a no-operation instruction
  localparam int unsigned NOP_WAIT_US = 50;
  localparam int unsigned NOP_CYC = NOP_WAIT_US * (CLK_HZ / 1_000_000);
  // register byte offsets
  localparam logic [7:0] OFS_TAB = 8'h04;
  localparam logic [7:0] OFS_TRIG = 8'h10;
  localparam logic [7:0] OFS_EN = 8'h14;
  localparam logic [7:0] OFS_START = 8'h18;
  localparam logic [7:0] OFS_SYSC = 8'h80;
  // system control fields and reset value
  localparam logic [31:0] SYSC_RST = 32'h3a98_0000;
  localparam int unsigned SC_TMO_LSB = 16;
  localparam int unsigned SC_RATE_LSB = 8;
  localparam int unsigned SC_DLY_LSB = 0;
  // instruction fields
  localparam int unsigned INS_END = 31;
  localparam int unsigned INS_PORT_LSB = 16;
  localparam int unsigned INS_PAT_LSB = 8;
  localparam int unsigned INS_LEN_LSB = 0;
  // pattern codes
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_GUN = 3'h2;
  localparam logic [2:0] PAT_RESET = 3'h3;
  localparam logic [2:0] PAT_UNGUN = 3'h4;
  localparam logic [2:0] PAT_NOP = 3'h7;
  // receive marker words and write-back block size
  localparam logic [31:0] MARK_TMO = 32'h0fff_ffff;
  localparam logic [31:0] MARK_PAR = 32'hffff_ff00;
  localparam logic [31:0] BLK_BYTES = 32'h0000_0020;

  typedef enum logic [2:0] {
    PSC_IDLE = 3'b000,
    PSC_RD_INS = 3'b001,
    PSC_RD_RXA = 3'b010,
    PSC_RD_TX = 3'b011,
    PSC_TX = 3'b100,
    PSC_RX = 3'b101,
    PSC_WR = 3'b110,
    PSC_NOP = 3'b111
  } psc_st_t;

  // one word request towards system memory
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } psc_mem_req_t;
endpackage
`default_nettype wire

// File: psc_dma.sv
/*
  serial command dma controller: apb registers, command file fetch,
  four-port two-line serial frame engine and 32-byte receive write-back.
  assumes one system clock, a memory port that acks each word request,
  and serial pins resolved outside from the output enables.
*/
// Design decisions made here: register access over APB and the register addresses.
`default_nettype none
module psc_dma #(
  parameter int unsigned HALF_MIN = psc_pkg::HP_MIN_CYC,
  parameter int unsigned NOP_CYC = psc_pkg::NOP_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic vblank_in,
  output psc_pkg::psc_mem_req_t mem_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  input wire logic [3:0] serial_line_first_in,
  output logic [3:0] serial_line_first_out,
  output logic [3:0] serial_line_first_oe_out,
  input wire logic [3:0] serial_line_second_in,
  output logic [3:0] serial_line_second_out,
  output logic [3:0] serial_line_second_oe_out,
  output logic busy_out
);
  // refuse divider or wait values the counters cannot hold
  if (HALF_MIN < 2 || HALF_MIN > 32) begin : g_bad_half
    $error("psc_dma: HALF_MIN out of range");
  end
  if (NOP_CYC < 1 || NOP_CYC > 65535) begin : g_bad_nop
    $error("psc_dma: NOP_CYC out of range");
  end

  typedef struct packed {
    psc_pkg::psc_st_t st;
    logic pr_rdy;
    logic pr_err;
    logic [31:0] pr_data;
    logic [31:0] tab;
    logic trig;
    logic en;
    logic busy;
    logic [31:0] sysc;
    logic [8:0] sy1;
    logic [8:0] sy2;
    logic [8:0] sy3;
    logic vb_arm;
    logic [15:0] dcnt;
    psc_pkg::psc_mem_req_t m;
    logic [31:0] ptr;
    logic [31:0] ins;
    logic [31:0] rxa;
    logic [31:0] txw;
    logic [8:0] wleft;
    logic [5:0] bitn;
    logic [1:0] ph;
    logic half;
    logic [7:0] hp;
    logic [7:0] par;
    logic [3:0] l1o;
    logic [3:0] l1e;
    logic [3:0] l2o;
    logic [3:0] l2e;
    logic gun;
    logic [15:0] tmr;
    logic rin;
    logic [2:0] rbit;
    logic [7:0] rbyte;
    logic [7:0] pend;
    logic pend_v;
    logic [31:0] wsh;
    logic [1:0] bcnt;
    logic [7:0][31:0] fifo;
    logic [3:0] fcnt;
    logic wr_busy;
    logic [2:0] widx;
    logic [31:0] wbase;
    logic mark;
    logic rd_pend;
  } psc_state_t;

  psc_state_t s_ff;
  psc_state_t nxt_s;
  logic [1:0] sel;
  logic [2:0] pat;
  logic [8:0] nwords;
  logic r1, r1p, r2, r2p;
  logic tick, vb_rise, rd_ack, hit, apb_wr, go, rd, adv;
  logic [7:0] hp_load;
  logic [31:0] rdat;
  logic [31:0] word;

  always_comb begin
    nxt_s = s_ff;
    rd = 1'b0;
    adv = 1'b0;
    hit = 1'b1;
    rdat = 32'h0;
    sel = s_ff.ins[psc_pkg::INS_PORT_LSB +: 2];
    pat = s_ff.ins[psc_pkg::INS_PAT_LSB +: 3];
    nwords = {1'b0, s_ff.ins[psc_pkg::INS_LEN_LSB +: 8]} + 9'h1;
    word = {s_ff.wsh[23:0], s_ff.pend};
    // two-flop pin synchronisers, third stage for edges
    nxt_s.sy1 = {vblank_in, serial_line_second_in, serial_line_first_in};
    nxt_s.sy2 = s_ff.sy1;
    nxt_s.sy3 = s_ff.sy2;
    r1 = s_ff.sy2[sel];
    r1p = s_ff.sy3[sel];
    r2 = s_ff.sy2[3'(sel) + 3'h4];
    r2p = s_ff.sy3[3'(sel) + 3'h4];
    vb_rise = s_ff.sy2[8] & ~s_ff.sy3[8];
    // half-bit timer, rate code scales the period
    hp_load = 8'((HALF_MIN << s_ff.sysc[psc_pkg::SC_RATE_LSB +: 2]) - 1);
    tick = (s_ff.hp == 8'h0);
    nxt_s.hp = tick ? hp_load : s_ff.hp - 8'h1;
    // memory handshake
    rd_ack = s_ff.m.req & mem_ack_in & ~s_ff.m.we;
    if (s_ff.m.req & mem_ack_in) begin
      nxt_s.m.req = 1'b0;
    end else if (s_ff.rd_pend & ~s_ff.m.req) begin
      nxt_s.m.req = 1'b1;
      nxt_s.rd_pend = 1'b0;
    end

    // apb read decode
    case (paddr_in)
      psc_pkg::OFS_TAB: rdat = s_ff.tab;
      psc_pkg::OFS_TRIG: rdat = {31'h0, s_ff.trig};
      psc_pkg::OFS_EN: rdat = {31'h0, s_ff.en};
      psc_pkg::OFS_START: rdat = {31'h0, s_ff.busy};
      psc_pkg::OFS_SYSC: rdat = s_ff.sysc;
      default: hit = 1'b0;
    endcase
    // apb answer one cycle into the access phase
    nxt_s.pr_rdy = psel_in & penable_in & ~s_ff.pr_rdy;
    nxt_s.pr_err = 1'b0;
    nxt_s.pr_data = 32'h0;
    if (nxt_s.pr_rdy) begin
      nxt_s.pr_err = ~hit;
      nxt_s.pr_data = pwrite_in ? 32'h0 : rdat;
    end
    apb_wr = psel_in & penable_in & pwrite_in & s_ff.pr_rdy & ~s_ff.pr_err;
    if (apb_wr) begin
      case (paddr_in)
        psc_pkg::OFS_TAB: nxt_s.tab = pwdata_in;
        psc_pkg::OFS_TRIG: nxt_s.trig = pwdata_in[0];
        psc_pkg::OFS_EN: nxt_s.en = pwdata_in[0];
        psc_pkg::OFS_SYSC: nxt_s.sysc = pwdata_in;
        default: ;
      endcase
    end
    // start: software write, or delayed vertical blank
    go = apb_wr & (paddr_in == psc_pkg::OFS_START) & pwdata_in[0] &
         s_ff.en & ~s_ff.trig & ~s_ff.busy;
    if (s_ff.vb_arm) begin
      if (s_ff.dcnt == 16'h0) begin
        go = s_ff.en & ~s_ff.busy;
        nxt_s.vb_arm = 1'b0;
      end else begin
        nxt_s.dcnt = s_ff.dcnt - 16'h1;
      end
    end else if (vb_rise & s_ff.trig & s_ff.en & ~s_ff.busy) begin
      nxt_s.vb_arm = 1'b1;
      nxt_s.dcnt = {s_ff.sysc[psc_pkg::SC_DLY_LSB +: 8], 8'h0};
    end

    // block write-back engine, eight words per block
    if (s_ff.m.req & mem_ack_in & s_ff.m.we) begin
      nxt_s.widx = s_ff.widx + 3'h1;
      if (s_ff.widx == 3'h7) begin
        nxt_s.wr_busy = 1'b0;
        nxt_s.wbase = s_ff.wbase + psc_pkg::BLK_BYTES;
      end
    end else if (s_ff.wr_busy & ~s_ff.m.req) begin
      nxt_s.m.req = 1'b1;
      nxt_s.m.we = 1'b1;
      nxt_s.m.addr = s_ff.wbase + {27'h0, s_ff.widx, 2'b00};
      nxt_s.m.wdata = s_ff.fifo[s_ff.widx];
    end

    unique case (s_ff.st)
      psc_pkg::PSC_IDLE: begin
        if (go) begin
          nxt_s.busy = 1'b1;
          nxt_s.ptr = s_ff.tab;
          nxt_s.st = psc_pkg::PSC_RD_INS;
          rd = 1'b1;
        end
      end
      psc_pkg::PSC_RD_INS: begin
        if (rd_ack) begin
          nxt_s.ins = mem_rdata_in;
          nxt_s.ptr = s_ff.ptr + 32'h4;
          nxt_s.st = psc_pkg::PSC_RD_RXA;
          rd = 1'b1;
        end
      end
      psc_pkg::PSC_RD_RXA: begin
        if (rd_ack) begin
          nxt_s.rxa = mem_rdata_in;
          nxt_s.ptr = s_ff.ptr + 32'h4;
          nxt_s.par = 8'h0;
          nxt_s.wleft = 9'h0;
          nxt_s.ph = 2'h0;
          nxt_s.bitn = 6'h0;
          if (pat == psc_pkg::PAT_NORMAL) begin
            nxt_s.wleft = nwords;
          end
          if (s_ff.gun & (pat != psc_pkg::PAT_UNGUN)) begin
            // ignored while the gun hold is on, skip its data
            if (pat == psc_pkg::PAT_NORMAL) begin
              nxt_s.ptr = s_ff.ptr + 32'h4 + {21'h0, nwords, 2'b00};
            end
            adv = 1'b1;
          end else if (pat == psc_pkg::PAT_NOP) begin
            nxt_s.tmr = 16'(NOP_CYC);
            nxt_s.st = psc_pkg::PSC_NOP;
          end else if (pat == psc_pkg::PAT_NORMAL) begin
            nxt_s.st = psc_pkg::PSC_RD_TX;
            rd = 1'b1;
          end else begin
            if (pat == psc_pkg::PAT_UNGUN) begin
              nxt_s.gun = 1'b0;
              nxt_s.l2e = 4'h0;
            end
            // pattern only frame, length ignored
            nxt_s.st = psc_pkg::PSC_TX;
            nxt_s.l1o[sel] = 1'b1;
            nxt_s.l2o[sel] = 1'b1;
            nxt_s.l1e[sel] = 1'b1;
            nxt_s.l2e[sel] = 1'b1;
          end
        end
      end
      psc_pkg::PSC_RD_TX: begin
        if (rd_ack) begin
          nxt_s.txw = mem_rdata_in;
          nxt_s.ptr = s_ff.ptr + 32'h4;
          nxt_s.par = s_ff.par ^ mem_rdata_in[31:24] ^ mem_rdata_in[23:16] ^
                      mem_rdata_in[15:8] ^ mem_rdata_in[7:0];
          nxt_s.st = psc_pkg::PSC_TX;
          nxt_s.half = 1'b0;
          if (s_ff.ph == 2'h0) begin
            nxt_s.l1o[sel] = 1'b1;
            nxt_s.l2o[sel] = 1'b1;
            nxt_s.l1e[sel] = 1'b1;
            nxt_s.l2e[sel] = 1'b1;
          end else begin
            nxt_s.l1o[sel] = 1'b0;
            nxt_s.l2o[sel] = mem_rdata_in[31];
          end
        end
      end
      psc_pkg::PSC_TX: begin
        if (tick) begin
          unique case (s_ff.ph)
            2'h0: begin
              // start: second line falls while first is high
              if (s_ff.bitn == 6'h0) begin
                nxt_s.l2o[sel] = 1'b0;
                nxt_s.bitn = 6'h1;
              end else if (s_ff.wleft != 9'h0) begin
                nxt_s.ph = 2'h1;
                nxt_s.bitn = 6'h0;
                nxt_s.half = 1'b0;
                nxt_s.l1o[sel] = 1'b0;
                nxt_s.l2o[sel] = s_ff.txw[31];
              end else begin
                nxt_s.ph = 2'h3;
                nxt_s.bitn = 6'h0;
                nxt_s.l1o[sel] = 1'b0;
              end
            end
            2'h1, 2'h2: begin
              // data and parity bits, msb first, sampled on rise
              if (!s_ff.half) begin
                nxt_s.l1o[sel] = 1'b1;
                nxt_s.half = 1'b1;
              end else if ((s_ff.ph == 2'h1) ? (s_ff.bitn != 6'd31) : (s_ff.bitn != 6'd7)) begin
                nxt_s.bitn = s_ff.bitn + 6'h1;
                nxt_s.txw = {s_ff.txw[30:0], 1'b0};
                nxt_s.l1o[sel] = 1'b0;
                nxt_s.l2o[sel] = s_ff.txw[30];
                nxt_s.half = 1'b0;
              end else if (s_ff.ph == 2'h2) begin
                nxt_s.ph = 2'h3;
                nxt_s.bitn = 6'h0;
                nxt_s.l1o[sel] = 1'b0;
                nxt_s.l2o[sel] = 1'b0;
              end else if (s_ff.wleft == 9'h1) begin
                nxt_s.wleft = 9'h0;
                nxt_s.ph = 2'h2;
                nxt_s.bitn = 6'h0;
                nxt_s.half = 1'b0;
                nxt_s.txw = {s_ff.par, 24'h0};
                nxt_s.l1o[sel] = 1'b0;
                nxt_s.l2o[sel] = s_ff.par[7];
              end else begin
                nxt_s.wleft = s_ff.wleft - 9'h1;
                nxt_s.bitn = 6'h0;
                nxt_s.st = psc_pkg::PSC_RD_TX;
                rd = 1'b1;
              end
            end
            2'h3: begin
              // end: second line rises while first is high
              if (s_ff.bitn == 6'h0) begin
                nxt_s.l1o[sel] = 1'b1;
                nxt_s.bitn = 6'h1;
              end else if (s_ff.bitn == 6'h1) begin
                nxt_s.l2o[sel] = 1'b1;
                nxt_s.bitn = 6'h2;
              end else begin
                nxt_s.l1e[sel] = 1'b0;
                nxt_s.l2e[sel] = 1'b0;
                if (pat == psc_pkg::PAT_NORMAL) begin
                  nxt_s.st = psc_pkg::PSC_RX;
                  nxt_s.tmr = s_ff.sysc[psc_pkg::SC_TMO_LSB +: 16];
                  nxt_s.rin = 1'b0;
                  nxt_s.rbit = 3'h0;
                  nxt_s.pend_v = 1'b0;
                  nxt_s.bcnt = 2'h0;
                  nxt_s.fcnt = 4'h0;
                  nxt_s.par = 8'h0;
                  nxt_s.mark = 1'b0;
                  nxt_s.wbase = s_ff.rxa;
                end else begin
                  if (pat == psc_pkg::PAT_GUN) begin
                    nxt_s.gun = 1'b1;
                    nxt_s.l2o[sel] = 1'b0;
                    nxt_s.l2e[sel] = 1'b1;
                  end
                  adv = 1'b1;
                end
              end
            end
            default: ;
          endcase
        end
      end
      psc_pkg::PSC_RX: begin
        nxt_s.tmr = s_ff.tmr - 16'h1;
        if (s_ff.tmr == 16'h0) begin
          nxt_s.fifo[0] = psc_pkg::MARK_TMO;
          nxt_s.fcnt = 4'h8;
          nxt_s.mark = 1'b1;
          nxt_s.st = psc_pkg::PSC_WR;
        end else if (!s_ff.rin) begin
          if (r1 & r1p & r2p & ~r2) begin
            nxt_s.rin = 1'b1;
            nxt_s.tmr = s_ff.sysc[psc_pkg::SC_TMO_LSB +: 16];
          end
        end else if (r1 & r1p & ~r2p & r2) begin
          // frame end: held byte is parity, not data
          if (!s_ff.pend_v || s_ff.pend != s_ff.par) begin
            nxt_s.fifo[0] = psc_pkg::MARK_PAR;
            nxt_s.fcnt = 4'h8;
            nxt_s.mark = 1'b1;
          end
          nxt_s.st = psc_pkg::PSC_WR;
        end else if (r1 & ~r1p) begin
          nxt_s.rbyte = {s_ff.rbyte[6:0], r2};
          nxt_s.rbit = s_ff.rbit + 3'h1;
          nxt_s.tmr = s_ff.sysc[psc_pkg::SC_TMO_LSB +: 16];
          if (s_ff.rbit == 3'h7) begin
            nxt_s.pend = {s_ff.rbyte[6:0], r2};
            nxt_s.pend_v = 1'b1;
            if (s_ff.pend_v) begin
              nxt_s.wsh = word;
              nxt_s.par = s_ff.par ^ s_ff.pend;
              nxt_s.bcnt = s_ff.bcnt + 2'h1;
              if (s_ff.bcnt == 2'h3) begin
                nxt_s.fifo[s_ff.fcnt[2:0]] = word;
                nxt_s.fcnt = s_ff.fcnt + 4'h1;
                if (s_ff.fcnt == 4'h7) begin
                  nxt_s.fcnt = 4'h0;
                  nxt_s.wr_busy = 1'b1;
                  nxt_s.widx = 3'h0;
                end
              end
            end
          end
        end
      end
      psc_pkg::PSC_WR: begin
        if (!s_ff.wr_busy && !s_ff.m.req) begin
          if (s_ff.fcnt != 4'h0) begin
            // partial or marker block still goes out as 32 bytes
            nxt_s.wr_busy = 1'b1;
            nxt_s.widx = 3'h0;
            nxt_s.fcnt = 4'h0;
            nxt_s.mark = 1'b0;
            if (s_ff.mark) begin
              nxt_s.wbase = s_ff.rxa;
            end
          end else begin
            adv = 1'b1;
          end
        end
      end
      psc_pkg::PSC_NOP: begin
        nxt_s.tmr = s_ff.tmr - 16'h1;
        if (s_ff.tmr == 16'h0) begin
          adv = 1'b1;
        end
      end
    endcase

    // move on to the next unit or stop on the end flag
    if (adv) begin
      if (s_ff.ins[psc_pkg::INS_END]) begin
        nxt_s.st = psc_pkg::PSC_IDLE;
        nxt_s.busy = 1'b0;
      end else begin
        nxt_s.st = psc_pkg::PSC_RD_INS;
        rd = 1'b1;
      end
    end
    // queue a word read at the updated pointer, bus idles a cycle first
    if (rd) begin
      nxt_s.rd_pend = 1'b1;
      nxt_s.m.we = 1'b0;
      nxt_s.m.addr = nxt_s.ptr;
      nxt_s.m.wdata = 32'h0;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_ff <= '0;
      s_ff.sysc <= psc_pkg::SYSC_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state register
  assign prdata_out = s_ff.pr_data;
  assign pready_out = s_ff.pr_rdy;
  assign pslverr_out = s_ff.pr_err;
  assign mem_out = s_ff.m;
  assign serial_line_first_out = s_ff.l1o;
  assign serial_line_first_oe_out = s_ff.l1e;
  assign serial_line_second_out = s_ff.l2o;
  assign serial_line_second_oe_out = s_ff.l2e;
  assign busy_out = s_ff.busy;
endmodule
`default_nettype wire

// File: psc_dma_checker.sv
/*
  checker for psc_dma: apb answer timing, memory request hold and pin enables.
  assumes binding onto psc_dma with one clock and an active-low async reset.
*/
`default_nettype none
module psc_dma_checker (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire psc_pkg::psc_mem_req_t mem_out,
  input wire logic mem_ack_in,
  input wire logic [3:0] serial_line_first_oe_out,
  input wire logic [3:0] serial_line_second_oe_out,
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  logic mapped;
  // decoded register window
  assign mapped = paddr_in inside {8'h04, 8'h10, 8'h14, 8'h18, 8'h80};
  // apb answer one cycle into the access phase, then gone
  property p_rdy_next; psel_in && $rose(penable_in) |=> pready_out; endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("pready not in 2nd cycle");
  property p_rdy_once; pready_out |=> !pready_out; endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("pready longer than 1 cycle");
  property p_err_map; pready_out |-> (pslverr_out == !mapped); endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_rd_zero; !pready_out |-> prdata_out == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside answer");
  // memory request held steady until acked, dropped after
  property p_req_hold;
    mem_out.req && !mem_ack_in |=> mem_out.req && $stable(mem_out.addr) && $stable(mem_out.we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_gap; mem_out.req && mem_ack_in |=> !mem_out.req; endproperty
  a_req_gap: assert property (p_req_gap) else $error("request not dropped after ack");
  property p_wr_align; mem_out.req && mem_out.we |-> mem_out.addr[1:0] == 2'h0; endproperty
  a_wr_align: assert property (p_wr_align) else $error("unaligned word write");
  // pin enables: one port, line1 only with line2, line1 quiet when idle
  property p_one_port; $onehot0(serial_line_first_oe_out); endproperty
  a_one_port: assert property (p_one_port) else $error("two ports driven");
  property p_pair; (serial_line_first_oe_out & ~serial_line_second_oe_out) == 4'h0; endproperty
  a_pair: assert property (p_pair) else $error("line1 driven alone");
  property p_idle; !busy_out |-> serial_line_first_oe_out == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("line1 driven while idle");
  c_wr: cover property (mem_out.req && mem_out.we && mem_ack_in);
  c_err: cover property (pready_out && pslverr_out);
  c_hold: cover property (!busy_out && serial_line_second_oe_out != 4'h0);
  c_busy: cover property ($rose(busy_out));
endmodule
bind psc_dma psc_dma_checker u_psc_dma_checker (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .mem_out(mem_out),
  .mem_ack_in(mem_ack_in), .serial_line_first_oe_out(serial_line_first_oe_out),
  .serial_line_second_oe_out(serial_line_second_oe_out), .busy_out(busy_out));
`default_nettype wire

// File: psc_partner.sv
/*
  far side of psc_dma: word memory with varying ack latency, and four
  peripherals that capture sent frames and answer with one reply word.
  assumes pull-ups on every serial line and mode 0/1/2 = silent/good/bad parity.
*/
`default_nettype none
module psc_partner (
  input wire logic clk_in,
  input wire psc_pkg::psc_mem_req_t mem_in,
  output logic mem_ack_out = 1'b0,
  output logic [31:0] mem_rdata_out = 32'h0,
  input wire logic [3:0] l1_o_in,
  input wire logic [3:0] l1_oe_in,
  input wire logic [3:0] l2_o_in,
  input wire logic [3:0] l2_oe_in,
  input wire logic [7:0] mode_in,
  output logic [3:0] l1_out,
  output logic [3:0] l2_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:1023];
  logic [40:0] cap [0:3] = '{41'h0, 41'h0, 41'h0, 41'h0};
  logic [3:0] pd = 4'h0, v1 = 4'hf, v2 = 4'hf, pe = 4'h0, pc = 4'h0, po = 4'h0;
  logic [1:0] wc = 2'h0;
  // wired lines, pull-up when nobody drives
  assign l1_out = (l1_oe_in & l1_o_in) | (~l1_oe_in & (~pd | v1));
  assign l2_out = (l2_oe_in & l2_o_in) | (~l2_oe_in & (~pd | v2));
  // memory acks on a free-running phase, so waits vary from 0 to 3 cycles
  always @(posedge clk_in) begin
    mem_ack_out <= 1'b0;
    wc <= wc + 2'h1;
    if (mem_in.req && !mem_ack_out && wc == 2'h3) begin
      mem_ack_out <= 1'b1;
      mem_rdata_out <= mem[mem_in.addr[11:2]];
      if (mem_in.we) mem[mem_in.addr[11:2]] <= mem_in.wdata;
    end
    // frame capture: line2 shifted in on each line1 rise while driven
    pe <= l1_oe_in;
    pc <= l1_o_in & l1_oe_in;
    for (int p = 0; p < 4; p++) begin
      if (l1_oe_in[p] && pe[p] && l1_o_in[p] && !pc[p]) cap[p] <= {cap[p][39:0], l2_o_in[p]};
    end
  end
  task automatic hp();
    repeat (10) @(posedge clk_in);
  endtask
  // reply frame: start, one word plus parity, end
  task automatic send(input int p, input logic [1:0] m);
    logic [39:0] b;
    b = {32'ha5c3_0f96, (m == 2'h1) ? 8'hff : 8'h00};
    repeat (40) @(posedge clk_in);
    pd[p] = 1'b1;
    hp();
    v2[p] = 1'b0;
    hp();
    for (int i = 39; i >= 0; i--) begin
      v1[p] = 1'b0;
      v2[p] = b[i];
      hp();
      v1[p] = 1'b1;
      hp();
    end
    v1[p] = 1'b0;
    v2[p] = 1'b0;
    hp();
    v1[p] = 1'b1;
    hp();
    v2[p] = 1'b1;
    hp();
    pd[p] = 1'b0;
  endtask
  // answer once the device lets go of a port
  initial begin
    forever begin
      @(posedge clk_in);
      for (int p = 0; p < 4; p++) begin
        if (po[p] && !l1_oe_in[p] && mode_in[2*p+:2] != 2'h0) send(p, mode_in[2*p+:2]);
      end
      po = l1_oe_in;
    end
  end
endmodule
`default_nettype wire

// File: tb_peripheral_serial_command_dma.sv
/*
  testbench for psc_dma: registers over apb, a command file run, vblank start.
  assumes psc_partner as memory and peripherals; short nop wait of 20 cycles.
*/
`default_nettype none
module tb_peripheral_serial_command_dma;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, vb = 1'b0;
  logic rdy, err, busy, ack, sv;
  logic [7:0] pa = 8'h00, mode = 8'h00;
  logic [31:0] pwd = 32'h0, prd, mrd, rv;
  logic [3:0] l1, l2, o1, e1, o2, e2;
  psc_pkg::psc_mem_req_t mreq;
  int errors = 0, compares = 0, cyc = 0;
  // 40 mhz clock
  always #12.5 clk = ~clk;
  psc_dma #(.NOP_CYC(20)) u_psc_dma (.clk_sys_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(err), .vblank_in(vb), .mem_out(mreq), .mem_ack_in(ack),
    .mem_rdata_in(mrd), .serial_line_first_in(l1), .serial_line_first_out(o1),
    .serial_line_first_oe_out(e1), .serial_line_second_in(l2), .serial_line_second_out(o2),
    .serial_line_second_oe_out(e2), .busy_out(busy));
  psc_partner u_psc_partner (.clk_in(clk), .mem_in(mreq), .mem_ack_out(ack),
    .mem_rdata_out(mrd), .l1_o_in(o1), .l1_oe_in(e1), .l2_o_in(o2), .l2_oe_in(e2),
    .mode_in(mode), .l1_out(l1), .l2_out(l2));
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; answer left in rv and sv
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rv = prd;
    sv = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_busy(input logic lv, input int lim);
    int n;
    n = 0;
    while (busy !== lv && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("busy", {31'h0, lv}, {31'h0, busy});
  endtask
  task automatic pulse();
    @(posedge clk);
    vb <= 1'b1;
    repeat (4) @(posedge clk);
    vb <= 1'b0;
  endtask
  task automatic t_regs();
    logic [7:0] a [3];
    a = '{psc_pkg::OFS_EN, psc_pkg::OFS_TRIG, psc_pkg::OFS_START};
    apb(1'b0, psc_pkg::OFS_SYSC, 32'h0);
    chk("sysctl", psc_pkg::SYSC_RST, rv);
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0);
      chk("reset value", 32'h0, rv);
    end
    apb(1'b1, 8'h0c, 32'h1);
    chk("unmapped wr", 32'h1, {31'h0, sv});
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped rd", 32'h1, {31'h0, sv} & {31'h0, rv == 32'h0});
    apb(1'b1, psc_pkg::OFS_START, 32'h1);
    apb(1'b0, psc_pkg::OFS_START, 32'h0);
    chk("start no en", 32'h0, rv);
    apb(1'b1, psc_pkg::OFS_TAB, 32'h00c0_0100);
    apb(1'b0, psc_pkg::OFS_TAB, 32'h0);
    chk("table addr", 32'h00c0_0100, rv);
    $display("test regs done");
  endtask
  // ports b good, c silent, a bad parity, then nop with end flag
  task automatic t_run();
    logic [31:0] u [11];
    logic [31:0] tx [3];
    logic [8:0] pz [3];
    u = '{32'h0001_0000, 32'h00c0_0200, 32'h1234_5678, 32'h0002_0000, 32'h00c0_0240,
      32'hcafe_0001, 32'h0000_0000, 32'h00c0_0280, 32'h0000_00ff, 32'h8003_0700, 32'h00c0_02c0};
    tx = '{32'h0000_00ff, 32'h1234_5678, 32'hcafe_0001};
    pz = '{9'h1fe, 9'h010, 9'h06a};
    foreach (u[i]) u_psc_partner.mem[64+i] = u[i];
    mode = 8'h06;
    apb(1'b1, psc_pkg::OFS_SYSC, 32'h0200_0000);
    apb(1'b1, psc_pkg::OFS_EN, 32'h1);
    apb(1'b1, psc_pkg::OFS_START, 32'h1);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 20000);
    chk("reply b", 32'ha5c3_0f96, u_psc_partner.mem[128]);
    chk("reply c", psc_pkg::MARK_TMO, u_psc_partner.mem[144]);
    chk("reply a", psc_pkg::MARK_PAR, u_psc_partner.mem[160]);
    foreach (tx[p]) begin
      chk("tx word", tx[p], u_psc_partner.cap[p][40:9]);
      chk("tx parity", {23'h0, pz[p]}, {23'h0, u_psc_partner.cap[p][8:0]});
    end
    chk("port d", 32'h0, u_psc_partner.cap[3][31:0]);
    apb(1'b0, psc_pkg::OFS_START, 32'h0);
    chk("status", 32'h0, rv);
    $display("test run done");
  endtask
  task automatic t_gun();
    mode = 8'h00;
    u_psc_partner.mem[192] = 32'h8000_0200;
    u_psc_partner.mem[193] = 32'h00c0_0300;
    u_psc_partner.mem[194] = 32'h8000_0400;
    u_psc_partner.mem[195] = 32'h00c0_0300;
    apb(1'b1, psc_pkg::OFS_TRIG, 32'h1);
    apb(1'b1, psc_pkg::OFS_START, 32'h1);
    apb(1'b0, psc_pkg::OFS_START, 32'h0);
    chk("sw start", 32'h0, rv);
    apb(1'b1, psc_pkg::OFS_TAB, 32'h00c0_0300);
    pulse();
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 5000);
    chk("hold oe", 32'h1, {28'h0, e2});
    chk("hold level", 32'h0, {31'h0, l2[0]});
    chk("line1 oe", 32'h0, {28'h0, e1});
    apb(1'b1, psc_pkg::OFS_SYSC, 32'h0200_0001);
    apb(1'b1, psc_pkg::OFS_TAB, 32'h00c0_0308);
    pulse();
    repeat (100) @(posedge clk);
    chk("delayed", 32'h0, {31'h0, busy});
    wait_busy(1'b1, 400);
    wait_busy(1'b0, 5000);
    chk("release", 32'h0, {28'h0, e2});
    $display("test gun done");
  endtask
  // reset, then scenarios
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_run();
    t_gun();
    finish_test();
  end
endmodule
`default_nettype wire
